// ===== verilog/dsl_pkg.sv
// constants, types and decode helpers for the serial load front end
package dsl_pkg;
    localparam int          WORD_BITS   = 16;
    localparam logic [4:0]  FRAME_BITS  = 5'h10;
    localparam logic [15:0] ZERO_SCALE  = 16'h0000;
    localparam logic [15:0] MID_SCALE   = 16'h8000;
    localparam logic [1:0]  POR_DONE    = 2'h3;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          SYNC_STAGES = 2;
    localparam logic [7:0]  PIN_SYNC_IDLE = 8'h82;

    typedef struct packed {
        logic hw_rst_n;
        logic rst_lvl;
        logic pwr_dn;
        logic mode;
        logic strobe_n;
        logic data_in;
        logic cs_n;
        logic sclk;
    } dsl_pins_t;

    typedef enum {
        FR_IDLE,
        FR_SHIFT
    } dsl_frame_t;

    function automatic logic [15:0] reset_value(input logic lvl);
        reset_value = lvl ? MID_SCALE : ZERO_SCALE;
    endfunction : reset_value
endpackage : dsl_pkg

// ===== verilog/dsl_fifo.sv
// word fifo between frame capture and input register
`timescale 1ns/1ps
module dsl_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_i,
    input  wire logic             reset_n_i,
    input  wire logic             clk_en_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (clk_en_i && push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (clk_en_i) begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : dsl_fifo

// ===== verilog/dsl_serial_load.sv
// serial word capture, input register, converter latch and serial readout
`timescale 1ns/1ps
// Notes on behaviour
// - load strobe low: latch follows each new input register word one clock later
// - load strobe high: latch holds whatever the input register does
// - load strobe falling low copies input register into latch
// - word is 16 bits shifted in under the serial clock
// - chip select low frames and enables shifting
// - data sampled on every rising serial clock edge, at least 16 per frame
// - frames under 16 bits are dropped, registers keep old values
// - longer frames keep the last 16 bits shifted in
// - chip select rising moves a valid word toward the input register
// - mode select high: serial output reads back the input register
// - standalone: previous input register shifts out while new word shifts in
// - standalone: after 16 clocks the readout gives zeros
// - mode select low: serial output forwards shifted data down the chain
// - chain output changes on falling edges, valid at rising edges
// - chip select high stops all shifting
// - one shared load strobe updates all chained latches together
// - reset pin low forces both registers to zero or midscale
// - power down keeps register contents and keeps accepting frames
module dsl_serial_load #(
    parameter int FIFO_DEPTH = dsl_pkg::FIFO_DEPTH
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    input  wire logic        clk_en_i,
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        serial_data_input_i,
    input  wire logic        load_strobe_n_i,
    input  wire logic        readout_mode_select_i,
    input  wire logic        reset_level_select_i,
    input  wire logic        power_down_pin_i,
    input  wire logic        hw_reset_n_i,
    input  wire logic        upd_hold_i,
    output logic             sdo_o,
    output logic             word_ready_o,
    output logic             power_down_o,
    output logic [15:0]      input_reg_o,
    output logic [15:0]      dac_latch_o
);
    localparam int NP = $bits(dsl_pkg::dsl_pins_t);

    dsl_pkg::dsl_pins_t pins_raw;
    dsl_pkg::dsl_pins_t pins_s;
    logic [NP-1:0]      meta_q;
    logic [NP-1:0]      sync_q;
    logic               sclk_prev_q;
    logic               sclk_rise;
    logic               sclk_fall;
    dsl_pkg::dsl_frame_t fr_q;
    logic               cs_rise;
    logic               cs_fall;
    logic               shift_en;
    logic [15:0]        shift_q;
    logic [15:0]        rb_q;
    logic [4:0]         cnt_q;
    logic               sdo_q;
    logic               push_valid;
    logic               pop_valid;
    logic               pop_ready;
    logic [15:0]        pop_data;
    logic [15:0]        input_q;
    logic [15:0]        dac_q;
    logic [1:0]         por_q;
    logic               por_busy;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    assign pins_raw = '{hw_rst_n: hw_reset_n_i, rst_lvl: reset_level_select_i,
                        pwr_dn: power_down_pin_i, mode: readout_mode_select_i,
                        strobe_n: load_strobe_n_i, data_in: serial_data_input_i,
                        cs_n: cs_n_i, sclk: sclk_i};

    genvar gi;
    generate
        for (gi = 0; gi < NP; gi++) begin : g_sync
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    meta_q[gi] <= dsl_pkg::PIN_SYNC_IDLE[gi];
                    sync_q[gi] <= dsl_pkg::PIN_SYNC_IDLE[gi];
                end else if (clk_en_i) begin
                    meta_q[gi] <= pins_raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    assign pins_s = dsl_pkg::dsl_pins_t'(sync_q);

    ////////////////////////////////////////////////////////////////////////////////
    // edge detection and frame state

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_prev_q <= 1'b0;
        end else if (clk_en_i) begin
            sclk_prev_q <= pins_s.sclk;
        end
    end

    assign sclk_rise = pins_s.sclk && !sclk_prev_q;
    assign sclk_fall = !pins_s.sclk && sclk_prev_q;
    assign cs_fall   = (fr_q == dsl_pkg::FR_IDLE) && !pins_s.cs_n;
    assign cs_rise   = (fr_q == dsl_pkg::FR_SHIFT) && pins_s.cs_n;
    assign shift_en  = (fr_q == dsl_pkg::FR_SHIFT) && !pins_s.cs_n && sclk_rise;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fr_q <= dsl_pkg::FR_IDLE;
        end else if (clk_en_i) begin
            case (fr_q)
                dsl_pkg::FR_IDLE: begin
                    if (cs_fall) begin
                        fr_q <= dsl_pkg::FR_SHIFT;
                    end
                end
                dsl_pkg::FR_SHIFT: begin
                    if (cs_rise) begin
                        fr_q <= dsl_pkg::FR_IDLE;
                    end
                end
                default: fr_q <= dsl_pkg::FR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // shift register and bit count

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_q <= '0;
            cnt_q   <= '0;
        end else if (clk_en_i) begin
            if (cs_fall) begin
                cnt_q <= '0;
            end else if (shift_en) begin
                shift_q <= {shift_q[14:0], pins_s.data_in};
                if (cnt_q != dsl_pkg::FRAME_BITS) begin
                    cnt_q <= cnt_q + 5'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // serial output: readback or chain pass-through

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rb_q  <= '0;
            sdo_q <= 1'b0;
        end else if (clk_en_i) begin
            if (cs_fall) begin
                rb_q  <= input_q;
                sdo_q <= pins_s.mode ? input_q[15] : shift_q[15];
            end else if (fr_q == dsl_pkg::FR_SHIFT && !pins_s.cs_n) begin
                if (sclk_rise) begin
                    rb_q <= {rb_q[14:0], 1'b0};
                end
                if (sclk_fall) begin
                    sdo_q <= pins_s.mode ? rb_q[15] : shift_q[15];
                end
            end
        end
    end

    assign sdo_o = sdo_q;

    ////////////////////////////////////////////////////////////////////////////////
    // word fifo

    assign push_valid = cs_rise && (cnt_q == dsl_pkg::FRAME_BITS);
    assign pop_ready  = !upd_hold_i && pins_s.hw_rst_n && !por_busy;

    dsl_fifo #(
        .WIDTH (dsl_pkg::WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .reset_n_i   (reset_n_i),
        .clk_en_i    (clk_en_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (word_ready_o),
        .in_data_i   (shift_q),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_data)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // input register and converter latch

    assign por_busy = (por_q != dsl_pkg::POR_DONE);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            por_q <= '0;
        end else if (clk_en_i && por_busy) begin
            por_q <= por_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            input_q <= dsl_pkg::ZERO_SCALE;
        end else if (clk_en_i) begin
            if (por_busy || !pins_s.hw_rst_n) begin
                input_q <= dsl_pkg::reset_value(pins_s.rst_lvl);
            end else if (pop_valid && pop_ready) begin
                input_q <= pop_data;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dac_q <= dsl_pkg::ZERO_SCALE;
        end else if (clk_en_i) begin
            if (por_busy || !pins_s.hw_rst_n) begin
                dac_q <= dsl_pkg::reset_value(pins_s.rst_lvl);
            end else if (!pins_s.strobe_n) begin
                dac_q <= input_q;
            end
        end
    end

    assign input_reg_o  = input_q;
    assign dac_latch_o  = dac_q;
    assign power_down_o = pins_s.pwr_dn;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);

    a_latch_follow: assert property (
        (clk_en_i && !pins_s.strobe_n && pins_s.hw_rst_n && !por_busy)
        |=> dac_q == $past(input_q))
        else $error("latch did not follow input register");

    a_latch_hold: assert property (
        (clk_en_i && pins_s.strobe_n && pins_s.hw_rst_n && !por_busy) |=> $stable(dac_q))
        else $error("latch changed while load strobe high");

    a_strobe_load: assert property (
        (clk_en_i && $fell(pins_s.strobe_n) && pins_s.hw_rst_n && !por_busy)
        |=> dac_q == $past(input_q))
        else $error("load strobe fall did not load latch");

    a_shift_sample: assert property (
        (clk_en_i && fr_q == dsl_pkg::FR_SHIFT && !pins_s.cs_n && sclk_rise)
        |=> shift_q[0] == $past(pins_s.data_in) && shift_q[15:1] == $past(shift_q[14:0]))
        else $error("serial bit not sampled");

    a_idle_frozen: assert property (
        pins_s.cs_n |=> $stable(shift_q))
        else $error("shift register moved with chip select high");

    a_stop_count: assert property (
        pins_s.cs_n |=> $stable(cnt_q))
        else $error("bit count moved with chip select high");

    a_frame_start: assert property (
        (clk_en_i && cs_fall) |=> fr_q == dsl_pkg::FR_SHIFT && cnt_q == 5'h00)
        else $error("frame start not taken");

    a_short_drop: assert property (
        (clk_en_i && cs_rise && cnt_q != dsl_pkg::FRAME_BITS && !pop_valid) |=> !pop_valid)
        else $error("short frame accepted");

    a_input_hold: assert property (
        (clk_en_i && !pop_valid && pins_s.hw_rst_n && !por_busy) |=> $stable(input_q))
        else $error("input register moved without a word");

    a_full_push: assert property (
        (clk_en_i && cs_rise && cnt_q == dsl_pkg::FRAME_BITS && word_ready_o) |=> pop_valid)
        else $error("valid frame not accepted");

    a_pop_load: assert property (
        (clk_en_i && pop_valid && pop_ready) |=> input_q == $past(pop_data))
        else $error("queued word not loaded");

    a_readback_load: assert property (
        (clk_en_i && cs_fall) |=> rb_q == $past(input_q))
        else $error("readback word not loaded");

    a_readback_first: assert property (
        (clk_en_i && cs_fall && pins_s.mode) |=> sdo_q == $past(input_q[15]))
        else $error("readback did not start with top bit");

    a_readback_shift: assert property (
        (clk_en_i && fr_q == dsl_pkg::FR_SHIFT && !pins_s.cs_n && sclk_rise)
        |=> rb_q == {$past(rb_q[14:0]), 1'b0})
        else $error("readback did not advance");

    a_sdo_steady: assert property (
        (!cs_fall && !sclk_fall) |=> $stable(sdo_q))
        else $error("serial output moved off a falling edge");

    a_count_limit: assert property (
        cnt_q <= dsl_pkg::FRAME_BITS)
        else $error("bit count past word length");

    a_readback_zero: assert property (
        (clk_en_i && pins_s.mode && fr_q == dsl_pkg::FR_SHIFT && !pins_s.cs_n
         && sclk_fall && cnt_q == dsl_pkg::FRAME_BITS && !cs_fall) |=> !sdo_q)
        else $error("readback not zero after word");

    a_chain_out: assert property (
        (clk_en_i && !pins_s.mode && fr_q == dsl_pkg::FR_SHIFT && !pins_s.cs_n
         && sclk_fall) |=> sdo_q == $past(shift_q[15]))
        else $error("chain output wrong");

    a_reset_level: assert property (
        (clk_en_i && !pins_s.hw_rst_n)
        |=> input_q == dsl_pkg::reset_value($past(pins_s.rst_lvl))
            && dac_q == input_q)
        else $error("reset level not applied");

    c_valid_frame: cover property (push_valid && word_ready_o);
    c_short_frame: cover property (cs_rise && cnt_q != dsl_pkg::FRAME_BITS);
    c_chain_shift: cover property (!pins_s.mode && sclk_fall && cnt_q == dsl_pkg::FRAME_BITS);
    c_strobe_load: cover property ($fell(pins_s.strobe_n) && dac_q != input_q);
    c_long_readback: cover property (pins_s.mode && sclk_fall && cnt_q == dsl_pkg::FRAME_BITS);
endmodule : dsl_serial_load

// ===== tb/dsl_host_model.sv
// host side driver of the four-wire serial link
`timescale 1ns/1ps
module dsl_host_model (
    input  wire logic clk_sys_i,
    input  wire logic sdo_i,
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      ser_data_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        ser_data_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask : tick

    ////////////////////////////////////////////////////////////////////////
    // one frame of nbits, msb first; rb gathers sdo just before each rise
    task automatic send(input logic [31:0] data, input int nbits, output logic [31:0] rb);
        rb = 32'h0000_0000;
        cs_n_o = 1'b0;
        tick(4);
        for (int i = nbits - 1; i >= 0; i--) begin
            ser_data_o = data[i];
            tick(4);
            rb = {rb[30:0], sdo_i};
            sclk_o = 1'b1;
            tick(4);
            sclk_o = 1'b0;
        end
        tick(2);
        cs_n_o = 1'b1;
        ser_data_o = ~ser_data_o;
        tick(4);
    endtask : send
endmodule : dsl_host_model

// ===== tb/dsl_serial_load_bench.sv
// self-checking bench for the serial load front end
`timescale 1ns/1ps
module dsl_serial_load_bench;
    logic        clk_sys_i, reset_n_i, sclk, cs_n, ser_data, sdo, strobe_n, mode;
    logic        rst_lvl, pwr_dn, hw_rst_n, upd_hold, word_ready, pd_out, clk_en;
    int          nbits;
    logic [15:0] input_reg, dac_latch, w, prev;
    logic [31:0] rb, r;
    logic [31:0] seed = 32'h0000_BF77;
    logic [15:0] exp_q[$];
    int          num_errors = 0;
    int          compares = 0;

    initial begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    dsl_host_model i_host (.clk_sys_i(clk_sys_i), .sdo_i(sdo), .sclk_o(sclk), .cs_n_o(cs_n),
                           .ser_data_o(ser_data));

    dsl_serial_load i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en),
        .sclk_i(sclk), .cs_n_i(cs_n), .serial_data_input_i(ser_data),
        .load_strobe_n_i(strobe_n),
        .readout_mode_select_i(mode), .reset_level_select_i(rst_lvl),
        .power_down_pin_i(pwr_dn), .hw_reset_n_i(hw_rst_n), .upd_hold_i(upd_hold), .sdo_o(sdo),
        .word_ready_o(word_ready), .power_down_o(pd_out), .input_reg_o(input_reg),
        .dac_latch_o(dac_latch));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit

    task automatic end_of_test();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    // every change of the input register takes the oldest expected word
    always @(input_reg) begin
        if (reset_n_i === 1'b1) begin
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("ERROR %0t unexpected input register %h", $time, input_reg);
            end else begin
                chk_word(input_reg, exp_q.pop_front(), "input register");
            end
        end
    end

    initial begin
        repeat (30000) @(posedge clk_sys_i);
        num_errors++;
        $display("ERROR %0t watchdog expired", $time);
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n_i = 1'b0;
        clk_en    = 1'b1;
        strobe_n  = 1'b0;
        mode      = 1'b1;
        rst_lvl   = 1'b1;
        pwr_dn    = 1'b0;
        hw_rst_n  = 1'b1;
        upd_hold  = 1'b0;
        exp_q.push_back(16'h8000);
        i_host.tick(2);
        reset_n_i = 1'b1;
        i_host.tick(8);
        chk_word(dac_latch, 16'h8000, "reset latch");
        prev = 16'h8000;
        // standalone readback, plain and overlong frames, latch transparent
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            w = r[15:0];
            nbits = 16 + 4 * (i % 3);
            exp_q.push_back(w);
            i_host.send(r, nbits, rb);
            rb = rb << (32 - nbits);
            chk_word(rb[31:16], prev, "readback");
            chk_word(rb[15:0], 16'h0000, "readback tail");
            i_host.tick(3);
            chk_word(dac_latch, w, "sync load");
            prev = w;
        end
        // two-device chain length with the strobe held high
        strobe_n = 1'b1;
        mode = 1'b0;
        i_host.tick(4);
        r = rnd();
        exp_q.push_back(r[15:0]);
        i_host.send(r, 32, rb);
        chk_word(rb[31:16], prev, "chain old word");
        chk_word(rb[15:0], r[31:16], "chain output");
        i_host.tick(3);
        chk_word(dac_latch, prev, "latch held");
        strobe_n = 1'b0;
        i_host.tick(5);
        chk_word(dac_latch, r[15:0], "strobe load");
        prev = r[15:0];
        // short frame is dropped; readback ignored
        i_host.send(rnd(), 10, rb);
        i_host.tick(4);
        chk_word(input_reg, prev, "short frame");
        chk_word(dac_latch, prev, "short frame latch");
        // power down keeps accepting frames
        pwr_dn = 1'b1;
        i_host.tick(4);
        chk_bit(pd_out, 1'b1, "power down");
        r = rnd();
        exp_q.push_back(r[15:0]);
        i_host.send(r, 16, rb);
        i_host.tick(3);
        chk_word(dac_latch, r[15:0], "power down load");
        pwr_dn = 1'b0;
        // fill the word fifo while drain is stalled, one more is lost
        upd_hold = 1'b1;
        for (int i = 0; i < 32; i++) begin
            r = rnd();
            exp_q.push_back(r[15:0]);
            i_host.send(r, 16, rb);
        end
        chk_bit(word_ready, 1'b0, "fifo full");
        i_host.send(rnd(), 16, rb);
        prev = r[15:0];
        upd_hold = 1'b0;
        i_host.tick(60);
        chk_bit(word_ready, 1'b1, "fifo drained");
        chk_bit(pd_out, 1'b0, "power up");
        chk_word(dac_latch, prev, "drained latch");
        // clock enable low: a whole frame passes unseen
        clk_en = 1'b0;
        i_host.send(rnd(), 16, rb);
        clk_en = 1'b1;
        i_host.tick(4);
        chk_word(input_reg, prev, "frozen frame");
        // hardware reset to zero scale
        rst_lvl = 1'b0;
        hw_rst_n = 1'b0;
        exp_q.push_back(16'h0000);
        i_host.tick(6);
        chk_word(dac_latch, 16'h0000, "hw reset latch");
        hw_rst_n = 1'b1;
        i_host.tick(6);
        chk_word(16'(exp_q.size()), 16'h0000, "pending words");
        end_of_test();
    end
endmodule : dsl_serial_load_bench
